// *** logic/bstx_core.sv ***
// Contract
// RQ1 - A skip on bit clear whose tested bit is 0 skips the next instruction with a dummy cycle.
// RQ2 - A skip on bit clear whose tested bit is 1 continues in sequence and touches no flag.
// RQ3 - The current-page table read fetches pc page plus table pointer, low byte to memory.
// RQ4 - Every table read loads the fetched high byte into the table-high register.
// RQ5 - The last-page table read uses the last page, low byte to memory, high byte to table-high.
// RQ6 - XOR into accumulator stores acc xor memory in acc and changes only the zero flag.
// RQ7 - XOR into memory stores acc xor memory back to memory and changes only the zero flag.
// RQ8 - XOR immediate stores acc xor immediate in acc and changes only the zero flag.
// RQ9 - The zero flag is set on an all-zero XOR result and cleared otherwise.
`timescale 1ns/10ps
module bstx_core (
  // Clock and reset
  input  wire logic                             clock_i,
  input  wire logic                             rst_i,
  // Decoded instruction
  input  wire logic                             op_valid_i,
  input  wire bstx_pkg::bstx_op_t               op_i,
  input  wire logic [bstx_pkg::DADDR_W-1:0]     mem_addr_i,
  input  wire logic [2:0]                       bit_sel_i,
  input  wire logic [bstx_pkg::DATA_W-1:0]      imm_i,
  input  wire logic [bstx_pkg::DATA_W-1:0]      table_pointer_i,
  // Data memory read data, combinational for mem_addr_i
  input  wire logic [bstx_pkg::DATA_W-1:0]      mem_rdata_i,
  // Program memory read data, combinational for the internal table address
  input  wire logic [bstx_pkg::PWORD_W-1:0]     prog_rdata_i,
  // Core state
  output logic [bstx_pkg::PADDR_W-1:0]          pc_o,
  output logic [bstx_pkg::DATA_W-1:0]           acc_o,
  output logic                                  zero_flag_o,
  output logic [bstx_pkg::DATA_W-1:0]           table_high_byte_reg_o,
  output logic                                  busy_o,
  // Program memory address
  output logic [bstx_pkg::PADDR_W-1:0]          prog_addr_o,
  // Data memory write
  output logic                                  mem_we_o,
  output logic [bstx_pkg::DADDR_W-1:0]          mem_waddr_o,
  output logic [bstx_pkg::DATA_W-1:0]           mem_wdata_o
);

  // ==========================================================================
  // Decode
  wire logic                           take;
  wire logic                           is_skip;
  wire logic                           is_tcur;
  wire logic                           is_tlast;
  wire logic                           is_tbl;
  wire logic                           is_xacc;
  wire logic                           is_xmem;
  wire logic                           is_ximm;
  wire logic                           is_xor;
  wire logic                           bit_clear;
  wire logic [bstx_pkg::DATA_W-1:0]    xor_operand;
  wire logic [bstx_pkg::DATA_W-1:0]    xor_result;
  wire logic [bstx_pkg::PADDR_W-1:0]   tbl_addr;
  wire logic [bstx_pkg::PADDR_W-1:0]   pc_next;

  typedef enum logic {BSTX_RUN, BSTX_DUMMY} bstx_state_t;
  bstx_state_t state_q;
  bstx_state_t state_d;

  logic [bstx_pkg::PADDR_W-1:0] pc_q;
  logic [bstx_pkg::DATA_W-1:0]  acc_q;
  logic                         zero_q;
  logic [bstx_pkg::DATA_W-1:0]  table_high_q;
  logic [bstx_pkg::PADDR_W-1:0] paddr_q;
  logic                         we_q;
  logic [bstx_pkg::DADDR_W-1:0] waddr_q;
  logic [bstx_pkg::DATA_W-1:0]  wdata_q;

  // Dummy cycle swallows any operation offered meanwhile
  assign take      = op_valid_i && (state_q == BSTX_RUN);
  assign is_skip   = take && (op_i == bstx_pkg::BSTX_OP_SKIP_CLR);
  assign is_tcur   = take && (op_i == bstx_pkg::BSTX_OP_TBL_CUR);
  assign is_tlast  = take && (op_i == bstx_pkg::BSTX_OP_TBL_LAST);
  assign is_tbl    = is_tcur || is_tlast;
  assign is_xacc   = take && (op_i == bstx_pkg::BSTX_OP_XOR_ACC);
  assign is_xmem   = take && (op_i == bstx_pkg::BSTX_OP_XOR_MEM);
  assign is_ximm   = take && (op_i == bstx_pkg::BSTX_OP_XOR_IMM);
  assign is_xor    = is_xacc || is_xmem || is_ximm;
  assign bit_clear = ~mem_rdata_i[bit_sel_i];
  assign xor_operand = is_ximm ? imm_i : mem_rdata_i; // RQ8
  assign xor_result  = acc_q ^ xor_operand; // RQ6 RQ7
  // Page bits come from pc or the fixed last page
  // Table word must answer in the same cycle; there is no wait state
  assign tbl_addr = is_tlast ? {bstx_pkg::LAST_PAGE, table_pointer_i} // RQ5
                             : {pc_q[bstx_pkg::PADDR_W-1:bstx_pkg::PAGE_W],
                                table_pointer_i}; // RQ3
  // Any taken op adds one to pc; no op holds it
  assign pc_next = take ? pc_q + 12'h001 : pc_q;

  // Dummy cycle lasts exactly one clock
  always_comb begin
    state_d = state_q;
    case (state_q)
      BSTX_RUN:   if (is_skip && bit_clear) state_d = BSTX_DUMMY; // RQ1
      BSTX_DUMMY: state_d = BSTX_RUN;
      default:    state_d = BSTX_RUN;
    endcase
  end

  // ==========================================================================
  // State
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= BSTX_RUN;
      pc_q    <= bstx_pkg::PC_RST;
    end else begin
      state_q <= state_d;
      pc_q    <= (state_q == BSTX_DUMMY) ? pc_q + 12'h001 : pc_next; // RQ1 RQ2
    end
  end

  // Accumulator written only by the XOR forms that target it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= bstx_pkg::ACC_RST;
    end else if (is_xacc || is_ximm) begin
      acc_q <= xor_result; // RQ6 RQ8
    end
  end

  // Only XOR touches the flag; skip and table reads leave it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      zero_q <= bstx_pkg::ZERO_RST;
    end else if (is_xor) begin
      zero_q <= (xor_result == 8'h00); // RQ9
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      table_high_q <= bstx_pkg::TABLE_HIGH_RST;
    end else if (is_tbl) begin
      table_high_q <= prog_rdata_i[15:8]; // RQ4
    end
  end

  // Address goes to memory only as a registered copy, one cycle late
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      paddr_q <= bstx_pkg::PC_RST;
    end else begin
      paddr_q <= tbl_addr;
    end
  end

  // One-cycle write pulse; the memory takes it at the next edge
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      we_q    <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      we_q    <= is_tbl || is_xmem;
      waddr_q <= mem_addr_i;
      wdata_q <= is_tbl ? prog_rdata_i[7:0] : xor_result; // RQ3 RQ5 RQ7
    end
  end

  // ==========================================================================
  // Outputs
  assign pc_o                  = pc_q;
  assign acc_o                 = acc_q;
  assign zero_flag_o           = zero_q;
  assign table_high_byte_reg_o = table_high_q;
  assign busy_o                = (state_q == BSTX_DUMMY);
  assign prog_addr_o           = paddr_q;
  assign mem_we_o              = we_q;
  assign mem_waddr_o           = waddr_q;
  assign mem_wdata_o           = wdata_q;

  // ==========================================================================
  // Checks
  a_skip_dummy_cycle: assert property (@(posedge clock_i) disable iff (rst_i) // RQ1
    is_skip && bit_clear |=> busy_o ##1 !busy_o && pc_o == $past(pc_o, 2) + 12'h002)
    else $error("skip did not take a dummy cycle");
  a_noskip_sequential: assert property (@(posedge clock_i) disable iff (rst_i) // RQ2
    is_skip && !bit_clear |=> !busy_o && pc_o == $past(pc_o) + 12'h001 && $stable(zero_flag_o))
    else $error("unskipped test did not proceed");
  a_tbl_cur_write: assert property (@(posedge clock_i) disable iff (rst_i) // RQ3
    is_tcur |=> mem_we_o && mem_wdata_o == $past(prog_rdata_i[7:0])
      && prog_addr_o[7:0] == $past(table_pointer_i) && $stable(zero_flag_o))
    else $error("current page table read wrong");
  a_tbl_high_load: assert property (@(posedge clock_i) disable iff (rst_i) // RQ4
    is_tbl |=> table_high_byte_reg_o == $past(prog_rdata_i[15:8]))
    else $error("table high byte not loaded");
  a_tbl_last_page: assert property (@(posedge clock_i) disable iff (rst_i) // RQ5
    is_tlast |=> prog_addr_o[11:8] == bstx_pkg::LAST_PAGE && mem_we_o)
    else $error("last page table read wrong");
  a_xor_acc_result: assert property (@(posedge clock_i) disable iff (rst_i) // RQ6
    is_xacc |=> acc_o == ($past(acc_o) ^ $past(mem_rdata_i)) && !mem_we_o)
    else $error("xor into acc wrong");
  a_xor_mem_result: assert property (@(posedge clock_i) disable iff (rst_i) // RQ7
    is_xmem |=> mem_we_o && mem_wdata_o == ($past(acc_o) ^ $past(mem_rdata_i))
      && $stable(acc_o))
    else $error("xor into memory wrong");
  a_xor_imm_result: assert property (@(posedge clock_i) disable iff (rst_i) // RQ8
    is_ximm |=> acc_o == ($past(acc_o) ^ $past(imm_i)))
    else $error("xor immediate wrong");
  a_zero_flag_value: assert property (@(posedge clock_i) disable iff (rst_i) // RQ9
    is_xor |=> zero_flag_o == ($past(xor_result) == 8'h00))
    else $error("zero flag wrong");
  a_skip_flag_kept: assert property (@(posedge clock_i) disable iff (rst_i) // RQ2
    is_skip |=> $stable(zero_flag_o) && $stable(acc_o) && !mem_we_o)
    else $error("skip changed a flag or result");
  a_dummy_drops_op: assert property (@(posedge clock_i) disable iff (rst_i) // RQ1
    busy_o |=> $stable(acc_o) && $stable(zero_flag_o) && !mem_we_o && !busy_o)
    else $error("dummy cycle executed an operation");

  // ==========================================================================
  // Coverage
  c_skip_taken: cover property (@(posedge clock_i) disable iff (rst_i) is_skip && bit_clear);
  c_skip_not_taken: cover property (@(posedge clock_i) disable iff (rst_i) is_skip && !bit_clear);
  c_tbl_cur: cover property (@(posedge clock_i) disable iff (rst_i) is_tcur);
  c_tbl_last: cover property (@(posedge clock_i) disable iff (rst_i) is_tlast);
  c_xor_zero: cover property (@(posedge clock_i) disable iff (rst_i) is_xor ##1 zero_flag_o);

endmodule : bstx_core

// *** logic/bstx_pkg.sv ***
package bstx_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned DADDR_W = 8;
  localparam int unsigned PADDR_W = 12;
  localparam int unsigned PWORD_W = 16;
  localparam int unsigned PAGE_W  = 8;

  // ==========================================================================
  // Operation codes on the decoded operation port
  typedef enum logic [2:0] {
    BSTX_OP_NOP        = 3'h0,
    BSTX_OP_SKIP_CLR   = 3'h1,
    BSTX_OP_TBL_CUR    = 3'h2,
    BSTX_OP_TBL_LAST   = 3'h3,
    BSTX_OP_XOR_ACC    = 3'h4,
    BSTX_OP_XOR_MEM    = 3'h5,
    BSTX_OP_XOR_IMM    = 3'h6
  } bstx_op_t;

  // ==========================================================================
  // Reset values and the fixed last page
  localparam logic [7:0]  ACC_RST        = 8'h00;
  localparam logic [7:0]  TABLE_HIGH_RST = 8'h00;
  localparam logic        ZERO_RST       = 1'b0;
  localparam logic [11:0] PC_RST         = 12'h000;
  localparam logic [3:0]  LAST_PAGE      = 4'hf;

endpackage : bstx_pkg

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  // Clock, reset and decoded instruction
  logic                       clock_i;
  logic                       rst_i;
  logic                       op_valid_i;
  bstx_pkg::bstx_op_t         op_i;
  logic [7:0]                 mem_addr_i;
  logic [2:0]                 bit_sel_i;
  logic [7:0]                 imm_i;
  logic [7:0]                 table_pointer_i;
  logic [7:0]                 mem_rdata_i;
  logic [15:0]                prog_rdata_i;
  // Outputs
  logic [11:0]                pc_o;
  logic [7:0]                 acc_o;
  logic                       zero_flag_o;
  logic [7:0]                 table_high_byte_reg_o;
  logic                       busy_o;
  logic [11:0]                prog_addr_o;
  logic                       mem_we_o;
  logic [7:0]                 mem_waddr_o;
  logic [7:0]                 mem_wdata_o;
  logic [11:0]                tbl_addr;
  logic [7:0]                 dmem [256];
  int                         mismatches;
  int                         comparisons;
  logic [11:0]                pc0;

  // ==========================================================================
  // Memory models, both answering in the same cycle
  assign mem_rdata_i  = dmem[mem_addr_i];
  assign tbl_addr     = (op_i == bstx_pkg::BSTX_OP_TBL_LAST) ?
                        {bstx_pkg::LAST_PAGE, table_pointer_i} : {pc_o[11:8], table_pointer_i};
  // High byte tracks the page so a wrong page shows in table-high
  assign prog_rdata_i = {tbl_addr[11:4], tbl_addr[7:0] ^ 8'h3c};
  always @(posedge clock_i) begin
    if (mem_we_o === 1'b1) dmem[mem_waddr_o] <= mem_wdata_o;
  end

  bstx_core bstx_core_i (.clock_i(clock_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .mem_addr_i(mem_addr_i), .bit_sel_i(bit_sel_i), .imm_i(imm_i),
    .table_pointer_i(table_pointer_i), .mem_rdata_i(mem_rdata_i),
    .prog_rdata_i(prog_rdata_i), .pc_o(pc_o), .acc_o(acc_o), .zero_flag_o(zero_flag_o),
    .table_high_byte_reg_o(table_high_byte_reg_o), .busy_o(busy_o),
    .prog_addr_o(prog_addr_o), .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
    .mem_wdata_o(mem_wdata_o));

  // ==========================================================================
  // Shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Offers one op; returns one cycle later with results visible
  task run_op(input bstx_pkg::bstx_op_t op, input logic [7:0] a, input logic [2:0] b,
              input logic [7:0] imm, input logic [7:0] tp);
    op_valid_i = 1'b1;
    op_i = op;
    mem_addr_i = a;
    bit_sel_i = b;
    imm_i = imm;
    table_pointer_i = tp;
    @(posedge clock_i);
    #1;
  endtask : run_op

  task idle;
    op_valid_i = 1'b0;
    @(posedge clock_i);
    #1;
  endtask : idle

  task stop_test;
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Scenarios
  task t_xor_imm;
    run_op(bstx_pkg::BSTX_OP_XOR_IMM, 8'h00, 3'h0, 8'ha5, 8'h00);
    chk(acc_o, 8'ha5);
    chk(zero_flag_o, 1'b0);
    run_op(bstx_pkg::BSTX_OP_XOR_IMM, 8'h00, 3'h0, 8'ha5, 8'h00);
    chk(acc_o, 8'h00);
    chk(zero_flag_o, 1'b1);
    idle;
  endtask : t_xor_imm

  task t_skip_taken;
    pc0 = pc_o;
    run_op(bstx_pkg::BSTX_OP_SKIP_CLR, 8'h10, 3'h0, 8'h00, 8'h00);
    chk(busy_o, 1'b1);
    chk(pc_o, pc0 + 12'h001);
    // Offered during the dummy cycle, must be dropped
    run_op(bstx_pkg::BSTX_OP_XOR_IMM, 8'h00, 3'h0, 8'hff, 8'h00);
    chk(busy_o, 1'b0);
    chk(pc_o, pc0 + 12'h002);
    chk(acc_o, 8'h00);
    chk(zero_flag_o, 1'b1);
    idle;
  endtask : t_skip_taken

  task t_xor_acc;
    run_op(bstx_pkg::BSTX_OP_XOR_ACC, 8'h20, 3'h0, 8'h00, 8'h00);
    chk(acc_o, 8'h3c);
    chk(zero_flag_o, 1'b0);
    chk(mem_we_o, 1'b0);
    // A plain nop must leave acc and memory alone and advance pc by one
    pc0 = pc_o;
    run_op(bstx_pkg::BSTX_OP_NOP, 8'h20, 3'h0, 8'h00, 8'h00);
    chk(acc_o, 8'h3c);
    chk(mem_we_o, 1'b0);
    chk(pc_o, pc0 + 12'h001);
    idle;
  endtask : t_xor_acc

  task t_skip_not_taken;
    pc0 = pc_o;
    run_op(bstx_pkg::BSTX_OP_SKIP_CLR, 8'h10, 3'h1, 8'h00, 8'h00);
    chk(busy_o, 1'b0);
    chk(pc_o, pc0 + 12'h001);
    chk(zero_flag_o, 1'b0);
    idle;
  endtask : t_skip_not_taken

  task t_xor_mem;
    run_op(bstx_pkg::BSTX_OP_XOR_MEM, 8'h21, 3'h0, 8'h00, 8'h00);
    chk(mem_we_o, 1'b1);
    chk(mem_waddr_o, 8'h21);
    chk(mem_wdata_o, 8'h00);
    chk(zero_flag_o, 1'b1);
    chk(acc_o, 8'h3c);
    idle;
    chk(dmem[8'h21], 8'h00);
  endtask : t_xor_mem

  task t_tables;
    // Back to back, zero flag must survive both
    run_op(bstx_pkg::BSTX_OP_TBL_CUR, 8'h30, 3'h0, 8'h00, 8'h42);
    chk(mem_we_o, 1'b1);
    chk(mem_waddr_o, 8'h30);
    chk(mem_wdata_o, 8'h7e);
    chk(prog_addr_o, 12'h042);
    chk(table_high_byte_reg_o, 8'h04);
    chk(zero_flag_o, 1'b1);
    run_op(bstx_pkg::BSTX_OP_TBL_LAST, 8'h31, 3'h0, 8'h00, 8'h9a);
    chk(mem_we_o, 1'b1);
    chk(mem_waddr_o, 8'h31);
    chk(mem_wdata_o, 8'ha6);
    chk(prog_addr_o, 12'hf9a);
    chk(table_high_byte_reg_o, 8'hf9);
    chk(zero_flag_o, 1'b1);
    idle;
  endtask : t_tables

  task t_reset;
    // Mid-run reset clears every register at once
    rst_i = 1'b1;
    @(posedge clock_i);
    #1;
    chk(pc_o, 12'h000);
    chk(acc_o, 8'h00);
    chk(zero_flag_o, 1'b0);
    chk(table_high_byte_reg_o, 8'h00);
    chk(busy_o, 1'b0);
    chk(mem_we_o, 1'b0);
    rst_i = 1'b0;
  endtask : t_reset

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    #20000;
    mismatches++;
    stop_test();
  end

  initial begin
    mismatches = 0;
    comparisons = 0;
    for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
    dmem[8'h10] = 8'hfe;
    dmem[8'h20] = 8'h3c;
    dmem[8'h21] = 8'h3c;
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = bstx_pkg::BSTX_OP_NOP;
    mem_addr_i = 8'h00;
    bit_sel_i = 3'h0;
    imm_i = 8'h00;
    table_pointer_i = 8'h00;
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    t_xor_imm();
    t_skip_taken();
    t_xor_acc();
    t_skip_not_taken();
    t_xor_mem();
    t_tables();
    t_reset();
    t_xor_imm();
    stop_test();
  end
endmodule : tb_top
